// [common/dfcc_regs.svh]
`ifndef DFCC_REGS_SVH
`define DFCC_REGS_SVH

// ----------------------------------------------------------------
// loop gain switching codes
// ----------------------------------------------------------------
`define DFCC_LOOP_PRIMARY 2'h0
`define DFCC_LOOP_SECONDARY 2'h1
`define DFCC_LOOP_BY_INPUT 2'h2
`define DFCC_LOOP_BY_RTC 2'h3
`define DFCC_DI_FUNC_GAIN_SWITCH 7'h36
`define DFCC_DI_COUNT 6

// ----------------------------------------------------------------
// limits, fixed point: gains 0.01, times 0.1 s or 0.01 s
// ----------------------------------------------------------------
`define DFCC_KP_MAX 10'h3e8
`define DFCC_TI_MAX 10'h3e8
`define DFCC_TD_MAX 10'h3e8
`define DFCC_FB_MAX 14'h2710
`define DFCC_FB_MIN 14'h0001
`define DFCC_PCT_FULL 10'h3e8
`define DFCC_PCT_DIV 24'h0003e8
`define DFCC_SCALE_MAX 3'h4
`define DFCC_UNIT_MAX 5'h17
`define DFCC_UNIT_PERCENT 5'h00
`define DFCC_SCURVE_MAX 8'hfa

// ----------------------------------------------------------------
// frequency in 0.1 Hz, forced frequency in Hz
// ----------------------------------------------------------------
`define DFCC_FREQ_MAX 13'h0fa0
`define DFCC_FORCED_MAX 9'h190

// ----------------------------------------------------------------
// direction lock codes
// ----------------------------------------------------------------
`define DFCC_DIR_BOTH 2'h0
`define DFCC_DIR_FWD_ONLY 2'h1
`define DFCC_DIR_REV_ONLY 2'h2

// ----------------------------------------------------------------
// carrier, selection in kHz, result in 0.1 kHz
// ----------------------------------------------------------------
`define DFCC_CARRIER_VARIABLE 5'h00
`define DFCC_CARRIER_LOWEST 5'h01
`define DFCC_CARRIER_SEL_MAX 5'h10
`define DFCC_CARRIER_LOWEST_X10 8'h0f
`define DFCC_CARRIER_SLV_MIN_X10 8'h28
`define DFCC_CARRIER_SOFT_CAP_X10 8'h50
`define DFCC_CARRIER_OVH_X10 8'h14

`endif

// [common/dfcc_pkg.sv]
package dfcc_pkg;

    // one closed-loop gain set
    typedef struct packed {
        logic [9:0] kp;
        logic [9:0] ti;
        logic [9:0] td;
    } dfcc_gain_t;

    // carrier settings
    typedef struct packed {
        logic [4:0] sel;
        logic [4:0] var_max;
        logic [4:0] var_min;
        logic [6:0] var_gain;
        logic soft_pwm;
        logic auto_lower;
        logic sensorless_vector_mode;
    } dfcc_carrier_cfg_t;

    // four s-curve times in 0.01 s
    typedef struct packed {
        logic [7:0] acc_start;
        logic [7:0] acc_end;
        logic [7:0] dec_start;
        logic [7:0] dec_end;
    } dfcc_scurve_t;

    // jump frequencies in 0.1 Hz and common width
    typedef struct packed {
        logic [11:0] f1;
        logic [11:0] f2;
        logic [11:0] f3;
        logic [7:0] width;
    } dfcc_jump_cfg_t;

    // one band as an interval
    typedef struct packed {
        logic act;
        logic [12:0] lo;
        logic [12:0] hi;
    } dfcc_band_t;

endpackage

// [design/dfcc_carrier.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dfcc_regs.svh"

module dfcc_carrier
    import dfcc_pkg::*;
(
    input wire dfcc_carrier_cfg_t cfg,
    input wire logic overheat,
    output logic [7:0] carrier_x10,
    output logic var_mode,
    output logic held
);

    // kHz to 0.1 kHz
    function automatic logic [7:0] khz_x10(input logic [4:0] k);
        khz_x10 = ({3'h0, k} << 3) + ({3'h0, k} << 1);
    endfunction

    // ----------------------------------------------------------------
    // variable carrier from limits and gain
    // ----------------------------------------------------------------
    wire logic min_bad = cfg.var_min > cfg.var_max;
    wire logic [4:0] span = cfg.var_max - cfg.var_min;
    wire logic [4:0] var_khz = (min_bad || cfg.sensorless_vector_mode) ? cfg.var_max :
        ({2'h0, span} > cfg.var_gain) ? cfg.var_max - cfg.var_gain[4:0] :
        cfg.var_min;

    // ----------------------------------------------------------------
    // selection decode and floors
    // ----------------------------------------------------------------
    wire logic [4:0] sel_k = (cfg.sel > `DFCC_CARRIER_SEL_MAX) ? `DFCC_CARRIER_SEL_MAX
        : cfg.sel;
    wire logic [7:0] base_x10 = (sel_k == `DFCC_CARRIER_VARIABLE) ? khz_x10(var_khz) :
        (sel_k == `DFCC_CARRIER_LOWEST) ? `DFCC_CARRIER_LOWEST_X10 :
        khz_x10(sel_k);
    wire logic [7:0] slv_x10 = (cfg.sensorless_vector_mode && base_x10 < `DFCC_CARRIER_SLV_MIN_X10) ?
        `DFCC_CARRIER_SLV_MIN_X10 : base_x10;

    // ----------------------------------------------------------------
    // soft switching cap and overheat lowering
    // ----------------------------------------------------------------
    wire logic [7:0] soft_x10 = (cfg.soft_pwm && slv_x10 > `DFCC_CARRIER_SOFT_CAP_X10) ?
        `DFCC_CARRIER_SOFT_CAP_X10 : slv_x10;
    wire logic lower = cfg.auto_lower && overheat;
    assign carrier_x10 = (lower && soft_x10 > `DFCC_CARRIER_OVH_X10) ?
        `DFCC_CARRIER_OVH_X10 : soft_x10;
    assign var_mode = (sel_k == `DFCC_CARRIER_VARIABLE) && !cfg.sensorless_vector_mode;
    assign held = carrier_x10 < slv_x10;

endmodule // dfcc_carrier

`default_nettype wire

// [design/dfcc_jump.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dfcc_regs.svh"

module dfcc_jump
    import dfcc_pkg::*;
(
    input wire dfcc_jump_cfg_t cfg,
    input wire logic [11:0] ref_freq,
    input wire logic [11:0] prev_freq,
    input wire logic ramping,
    output logic [11:0] out_freq,
    output logic in_band
);

    // band centred on its frequency
    function automatic dfcc_band_t mk_band(input logic [11:0] f, input logic [7:0] w);
        logic [12:0] half;
        half = {6'h00, w[7:1]};
        mk_band.act = f != 12'h000;
        mk_band.lo = ({1'b0, f} > half) ? {1'b0, f} - half : 13'h0000;
        mk_band.hi = {1'b0, f} + half;
    endfunction

    // widen an interval by every band that touches it
    function automatic dfcc_band_t grow(input dfcc_band_t cur, input dfcc_band_t b0,
        input dfcc_band_t b1, input dfcc_band_t b2);
        dfcc_band_t bl [3];
        grow = cur;
        bl[0] = b0;
        bl[1] = b1;
        bl[2] = b2;
        for (int i = 0; i < 3; i++)
        begin
            if (bl[i].act && bl[i].lo <= grow.hi && bl[i].hi >= grow.lo)
            begin
                grow.act = 1'b1;
                grow.lo = (bl[i].lo < grow.lo) ? bl[i].lo : grow.lo;
                grow.hi = (bl[i].hi > grow.hi) ? bl[i].hi : grow.hi;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // merged span around the reference
    // ----------------------------------------------------------------
    wire dfcc_band_t b0 = mk_band(cfg.f1, cfg.width);
    wire dfcc_band_t b1 = mk_band(cfg.f2, cfg.width);
    wire dfcc_band_t b2 = mk_band(cfg.f3, cfg.width);
    wire dfcc_band_t seed = '{act: 1'b0, lo: {1'b0, ref_freq}, hi: {1'b0, ref_freq}};
    wire dfcc_band_t pass1 = grow(seed, b0, b1, b2);
    wire dfcc_band_t span = grow(grow(pass1, b0, b1, b2), b0, b1, b2);

    // ----------------------------------------------------------------
    // hold at the edge on the side of the previous command when steady
    // ----------------------------------------------------------------
    wire logic [12:0] top = (span.hi > `DFCC_FREQ_MAX) ? `DFCC_FREQ_MAX : span.hi;
    wire logic [12:0] edge_sel = (prev_freq <= ref_freq) ? span.lo : top;
    assign in_band = pass1.act;
    assign out_freq = (pass1.act && !ramping) ? edge_sel[11:0] : ref_freq;

endmodule // dfcc_jump

`default_nettype wire

// [design/dfcc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dfcc_regs.svh"

module dfcc_top
    import dfcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire dfcc_gain_t gain_primary,
    input wire dfcc_gain_t gain_secondary,
    input wire logic [1:0] loop_sel,
    input wire logic [`DFCC_DI_COUNT*7-1:0] di_func,
    input wire logic [`DFCC_DI_COUNT-1:0] di_pins,
    input wire logic rtc_timer_in,
    input wire logic [13:0] max_feedback,
    input wire logic [9:0] target_pct,
    input wire logic [2:0] scaling,
    input wire logic [4:0] unit_sel,
    input wire logic [11:0] loop_freq,
    input wire logic fb_loss_warn_in,
    input wire logic [8:0] forced_hz,
    input wire logic [1:0] dir_lock,
    input wire logic run_fwd_in,
    input wire logic run_rev_in,
    input wire dfcc_carrier_cfg_t carrier_cfg,
    input wire logic overheat_in,
    input wire dfcc_scurve_t scurve,
    input wire logic [15:0] accel_time,
    input wire logic [15:0] decel_time,
    input wire dfcc_jump_cfg_t jump_cfg,
    input wire logic ramping,
    output dfcc_gain_t active_gain_r,
    output logic secondary_active_r,
    output logic [13:0] target_eng_r,
    output logic [2:0] decimal_pos_r,
    output logic [4:0] unit_r,
    output logic unit_percent_r,
    output logic [11:0] freq_cmd_r,
    output logic forced_active_r,
    output logic jump_hold_r,
    output logic run_fwd_r,
    output logic run_rev_r,
    output logic dir_reject_r,
    output logic [7:0] carrier_x10_r,
    output logic carrier_var_r,
    output logic carrier_held_r,
    output logic [16:0] accel_total_r,
    output logic [16:0] decel_total_r
);

    localparam int NSYNC = `DFCC_DI_COUNT + 5;

    // clamp a ten bit value
    function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lim);
        clamp10 = (v > lim) ? lim : v;
    endfunction

    // clamp an s-curve time
    function automatic logic [7:0] clamp_s(input logic [7:0] v);
        clamp_s = (v > `DFCC_SCURVE_MAX) ? `DFCC_SCURVE_MAX : v;
    endfunction

    // linear time plus half of both shaping times
    function automatic logic [16:0] ramp_total(input logic [15:0] lin,
        input logic [7:0] s_a, input logic [7:0] s_b);
        logic [8:0] sum;
        sum = {1'b0, clamp_s(s_a)} + {1'b0, clamp_s(s_b)};
        ramp_total = {1'b0, lin} + {9'h000, sum[8:1]};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    wire logic [NSYNC-1:0] pins_raw = {di_pins, rtc_timer_in, fb_loss_warn_in,
        run_fwd_in, run_rev_in, overheat_in};

    // two stages, only the second is read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    wire logic [`DFCC_DI_COUNT-1:0] di_s = sync2_r[NSYNC-1:5];
    wire logic rtc_s = sync2_r[4];
    wire logic fb_loss_s = sync2_r[3];
    wire logic fwd_s = sync2_r[2];
    wire logic rev_s = sync2_r[1];
    wire logic overheat_s = sync2_r[0];

    // ----------------------------------------------------------------
    // gain set selection
    // ----------------------------------------------------------------
    logic [`DFCC_DI_COUNT-1:0] di_hit;

    // inputs programmed for gain switching and active
    always_comb
    begin
        for (int i = 0; i < `DFCC_DI_COUNT; i++)
        begin
            di_hit[i] = di_s[i] && (di_func[i*7 +: 7] == `DFCC_DI_FUNC_GAIN_SWITCH);
        end
    end

    logic use_secondary;

    // pick gain set from switching selection
    always_comb
    begin
        unique case (loop_sel)
            `DFCC_LOOP_PRIMARY: use_secondary = 1'b0;
            `DFCC_LOOP_SECONDARY: use_secondary = 1'b1;
            `DFCC_LOOP_BY_INPUT: use_secondary = |di_hit;
            `DFCC_LOOP_BY_RTC: use_secondary = rtc_s;
        endcase
    end

    // secondary set held inside its ranges
    wire dfcc_gain_t sec_lim = '{kp: clamp10(gain_secondary.kp, `DFCC_KP_MAX),
        ti: clamp10(gain_secondary.ti, `DFCC_TI_MAX),
        td: clamp10(gain_secondary.td, `DFCC_TD_MAX)};
    wire dfcc_gain_t gain_nxt = use_secondary ? sec_lim : gain_primary;

    // ----------------------------------------------------------------
    // feedback scaling and display
    // ----------------------------------------------------------------
    wire logic [13:0] fb_full = (max_feedback > `DFCC_FB_MAX) ? `DFCC_FB_MAX :
        (max_feedback < `DFCC_FB_MIN) ? `DFCC_FB_MIN : max_feedback;
    wire logic [9:0] pct_lim = clamp10(target_pct, `DFCC_PCT_FULL);
    wire logic [23:0] eng_prod = {10'h000, fb_full} * {14'h0000, pct_lim};
    wire logic [23:0] eng_quot = eng_prod / `DFCC_PCT_DIV;
    wire logic [2:0] dp_nxt = (scaling > `DFCC_SCALE_MAX) ? `DFCC_SCALE_MAX : scaling;
    wire logic [4:0] unit_nxt = (unit_sel > `DFCC_UNIT_MAX) ? `DFCC_UNIT_MAX : unit_sel;

    // ----------------------------------------------------------------
    // frequency command, forced on feedback loss
    // ----------------------------------------------------------------
    wire logic [8:0] forced_lim = (forced_hz > `DFCC_FORCED_MAX) ? `DFCC_FORCED_MAX :
        forced_hz;
    wire logic [11:0] forced_x10 = ({3'h0, forced_lim} << 3) + ({3'h0, forced_lim} << 1);
    wire logic [11:0] ref_sel = fb_loss_s ? forced_x10 : loop_freq;
    wire logic [11:0] jump_out;
    wire logic jump_in_band;

    dfcc_jump u_jump (
        .cfg(jump_cfg),
        .ref_freq(ref_sel),
        .prev_freq(freq_cmd_r),
        .ramping(ramping),
        .out_freq(jump_out),
        .in_band(jump_in_band)
    );

    wire logic hold_nxt = jump_in_band && !ramping;

    // ----------------------------------------------------------------
    // direction lock
    // ----------------------------------------------------------------
    wire logic rej_rev = (dir_lock == `DFCC_DIR_FWD_ONLY) && rev_s;
    wire logic rej_fwd = (dir_lock == `DFCC_DIR_REV_ONLY) && fwd_s;
    wire logic fwd_nxt = fwd_s && !(dir_lock == `DFCC_DIR_REV_ONLY);
    wire logic rev_nxt = rev_s && !(dir_lock == `DFCC_DIR_FWD_ONLY);

    // ----------------------------------------------------------------
    // carrier selection
    // ----------------------------------------------------------------
    wire logic [7:0] carrier_nxt;
    wire logic var_nxt;
    wire logic held_nxt;

    dfcc_carrier u_carrier (
        .cfg(carrier_cfg),
        .overheat(overheat_s),
        .carrier_x10(carrier_nxt),
        .var_mode(var_nxt),
        .held(held_nxt)
    );

    // ----------------------------------------------------------------
    // s-curve ramp totals
    // ----------------------------------------------------------------
    wire logic [16:0] acc_nxt = ramp_total(accel_time, scurve.acc_start,
        scurve.acc_end);
    wire logic [16:0] dec_nxt = ramp_total(decel_time, scurve.dec_start,
        scurve.dec_end);

    // ----------------------------------------------------------------
    // loop and display outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            active_gain_r <= '0;
            secondary_active_r <= 1'b0;
            target_eng_r <= 14'h0000;
            decimal_pos_r <= 3'h0;
            unit_r <= 5'h00;
            unit_percent_r <= 1'b1;
        end
        else
        begin
            active_gain_r <= gain_nxt;
            secondary_active_r <= use_secondary;
            target_eng_r <= eng_quot[13:0];
            decimal_pos_r <= dp_nxt;
            unit_r <= unit_nxt;
            unit_percent_r <= unit_nxt == `DFCC_UNIT_PERCENT;
        end
    end

    // frequency and direction outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            freq_cmd_r <= 12'h000;
            forced_active_r <= 1'b0;
            jump_hold_r <= 1'b0;
            run_fwd_r <= 1'b0;
            run_rev_r <= 1'b0;
            dir_reject_r <= 1'b0;
        end
        else
        begin
            freq_cmd_r <= jump_out;
            forced_active_r <= fb_loss_s;
            jump_hold_r <= hold_nxt;
            run_fwd_r <= fwd_nxt;
            run_rev_r <= rev_nxt;
            dir_reject_r <= rej_rev || rej_fwd;
        end
    end

    // carrier and ramp outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            carrier_x10_r <= `DFCC_CARRIER_LOWEST_X10;
            carrier_var_r <= 1'b0;
            carrier_held_r <= 1'b0;
            accel_total_r <= 17'h00000;
            decel_total_r <= 17'h00000;
        end
        else
        begin
            carrier_x10_r <= carrier_nxt;
            carrier_var_r <= var_nxt;
            carrier_held_r <= held_nxt;
            accel_total_r <= acc_nxt;
            decel_total_r <= dec_nxt;
        end
    end

endmodule // dfcc_top

`default_nettype wire

// [dv/dfcc_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dfcc_stage_model (
    input wire logic clk,
    input wire logic heat_req,
    output logic overheat_in
);
    // heatsink sensor of the power stage, a plain level off the falling edge
    always_ff @(negedge clk)
    begin
        overheat_in <= heat_req;
    end
endmodule // dfcc_stage_model

`default_nettype wire

// [dv/dfcc_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module dfcc_top_checker
    import dfcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire dfcc_gain_t gain_primary,
    input wire dfcc_gain_t gain_secondary,
    input wire logic [1:0] loop_sel,
    input wire logic [13:0] max_feedback,
    input wire logic [9:0] target_pct,
    input wire logic fb_loss_warn_in,
    input wire logic [8:0] forced_hz,
    input wire logic [1:0] dir_lock,
    input wire logic run_fwd_in,
    input wire logic run_rev_in,
    input wire dfcc_carrier_cfg_t carrier_cfg,
    input wire dfcc_scurve_t scurve,
    input wire logic [15:0] accel_time,
    input wire dfcc_jump_cfg_t jump_cfg,
    input wire dfcc_gain_t active_gain_r,
    input wire logic secondary_active_r,
    input wire logic [13:0] target_eng_r,
    input wire logic [11:0] freq_cmd_r,
    input wire logic forced_active_r,
    input wire logic run_fwd_r,
    input wire logic run_rev_r,
    input wire logic dir_reject_r,
    input wire logic [7:0] carrier_x10_r,
    input wire logic carrier_held_r,
    input wire logic [16:0] accel_total_r
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // pin levels held long enough to cross the synchronisers
    sequence s_warn_held;
        (fb_loss_warn_in && jump_cfg.f1 == 12'h000 && jump_cfg.f2 == 12'h000
            && jump_cfg.f3 == 12'h000 && forced_hz <= 9'h190)[*4];
    endsequence
    sequence s_rev_locked;
        (dir_lock == 2'h1 && run_rev_in)[*4];
    endsequence
    sequence s_both_free;
        (dir_lock == 2'h0 && run_fwd_in && run_rev_in)[*4];
    endsequence

    a_gain_primary: assert property (loop_sel == 2'h0 |=>
        !secondary_active_r && active_gain_r == $past(gain_primary))
        else $error("primary gain set not selected");
    a_gain_secondary: assert property (loop_sel == 2'h1 && gain_secondary.kp <= 10'h3e8
        && gain_secondary.ti <= 10'h3e8 && gain_secondary.td <= 10'h3e8
        |=> secondary_active_r && active_gain_r == $past(gain_secondary))
        else $error("secondary gain set not selected");
    a_kp_clamp: assert property (loop_sel == 2'h1 && gain_secondary.kp > 10'h3e8
        |=> active_gain_r.kp == 10'h3e8)
        else $error("secondary gain not clamped");
    a_target_scale: assert property (max_feedback >= 14'h0001
        && max_feedback <= 14'h2710 && target_pct <= 10'h3e8
        |=> target_eng_r == 14'((24'($past(max_feedback)) * 24'($past(target_pct))) / 24'h3e8))
        else $error("target scaling wrong");
    a_forced_freq: assert property (s_warn_held |=> forced_active_r
        && freq_cmd_r == 12'($past(forced_hz)) * 12'h00a)
        else $error("forced frequency not applied");
    a_rev_reject: assert property (s_rev_locked |=> !run_rev_r && dir_reject_r)
        else $error("reverse run not rejected");
    a_both_accept: assert property (s_both_free |=>
        run_fwd_r && run_rev_r && !dir_reject_r)
        else $error("run request rejected while unlocked");
    a_carrier_fixed: assert property (carrier_cfg.sel >= 5'h02 && carrier_cfg.sel <= 5'h10
        && !carrier_cfg.soft_pwm && !carrier_cfg.auto_lower && !carrier_cfg.sensorless_vector_mode
        |=> carrier_x10_r == 8'($past(carrier_cfg.sel)) * 8'h0a && !carrier_held_r)
        else $error("fixed carrier wrong");
    a_slv_floor: assert property (carrier_cfg.sensorless_vector_mode && carrier_cfg.sel >= 5'h01
        && carrier_cfg.sel <= 5'h03 && !carrier_cfg.soft_pwm && !carrier_cfg.auto_lower
        |=> carrier_x10_r == 8'h28)
        else $error("sensorless carrier floor missed");
    a_soft_cap: assert property (carrier_cfg.soft_pwm && carrier_cfg.sel > 5'h08
        && carrier_cfg.sel <= 5'h10 && !carrier_cfg.auto_lower
        |=> carrier_x10_r == 8'h50 && carrier_held_r)
        else $error("soft switching cap missed");
    a_scurve_sum: assert property (scurve.acc_start <= 8'hfa && scurve.acc_end <= 8'hfa
        |=> accel_total_r == 17'($past(accel_time)) + (17'($past(scurve.acc_start))
        + 17'($past(scurve.acc_end))) / 17'h00002)
        else $error("acceleration total wrong");
endmodule // dfcc_top_checker

bind dfcc_top dfcc_top_checker u_dfcc_top_checker (.clk, .rst, .gain_primary,
    .gain_secondary, .loop_sel, .max_feedback, .target_pct, .fb_loss_warn_in, .forced_hz,
    .dir_lock, .run_fwd_in, .run_rev_in, .carrier_cfg, .scurve, .accel_time, .jump_cfg,
    .active_gain_r, .secondary_active_r, .target_eng_r, .freq_cmd_r, .forced_active_r,
    .run_fwd_r, .run_rev_r, .dir_reject_r, .carrier_x10_r, .carrier_held_r, .accel_total_r);

`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import dfcc_pkg::*;
;
    // stimulus and observed values
    logic clk = 1'b0, rst = 1'b1, rtc = 1'b0, warn = 1'b0, fwd = 1'b0, rev = 1'b0;
    logic heat = 1'b0, ramping = 1'b0, ovh, sec_act, upct, fact, jhold, rf, rr, rej, cvar, cheld;
    logic [1:0] loop_sel = '0, dir_lock = '0;
    logic [41:0] di_func = '0;
    logic [5:0] di_pins = '0;
    logic [13:0] max_fb = '0, teng;
    logic [9:0] tgt = '0;
    logic [2:0] scaling = '0, dpos;
    logic [4:0] unit_sel = '0, unit_o;
    logic [11:0] loop_freq = '0, fcmd;
    logic [8:0] forced = '0;
    logic [15:0] acc_t = '0, dec_t = '0;
    logic [7:0] car;
    logic [16:0] atot, dtot;
    dfcc_gain_t gp = '0, gs = '0, ag;
    dfcc_carrier_cfg_t ccfg = '0;
    dfcc_scurve_t sc = '0;
    dfcc_jump_cfg_t jcfg = '0;
    int n_mismatch = 0, check_count = 0;

    always #10 clk = ~clk;

    dfcc_stage_model u_dfcc_stage_model (.clk(clk), .heat_req(heat), .overheat_in(ovh));

    dfcc_top u_dfcc_top (.clk(clk), .rst(rst), .gain_primary(gp), .gain_secondary(gs),
        .loop_sel(loop_sel), .di_func(di_func), .di_pins(di_pins), .rtc_timer_in(rtc),
        .max_feedback(max_fb), .target_pct(tgt), .scaling(scaling), .unit_sel(unit_sel),
        .loop_freq(loop_freq), .fb_loss_warn_in(warn), .forced_hz(forced), .dir_lock(dir_lock),
        .run_fwd_in(fwd), .run_rev_in(rev), .carrier_cfg(ccfg), .overheat_in(ovh),
        .scurve(sc), .accel_time(acc_t), .decel_time(dec_t), .jump_cfg(jcfg),
        .ramping(ramping), .active_gain_r(ag), .secondary_active_r(sec_act),
        .target_eng_r(teng), .decimal_pos_r(dpos), .unit_r(unit_o), .unit_percent_r(upct),
        .freq_cmd_r(fcmd), .forced_active_r(fact), .jump_hold_r(jhold), .run_fwd_r(rf),
        .run_rev_r(rr), .dir_reject_r(rej), .carrier_x10_r(car), .carrier_var_r(cvar),
        .carrier_held_r(cheld), .accel_total_r(atot), .decel_total_r(dtot));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // long enough for pin synchronisers and the output register
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_loop();
        logic sec;
        gp = '{kp:10'h064, ti:10'h0c8, td:10'h012};
        gs = '{kp:10'h3ff, ti:10'h050, td:10'h3e8};
        di_func[27:21] = 7'h36;
        for (int s = 0; s < 4; s++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                loop_sel = 2'(s);
                di_pins[3] = p[0];
                rtc = ~p[0];
                settle();
                sec = (s == 1) || (s == 2 && p == 1) || (s == 3 && p == 0);
                check(sec_act, sec);
                check(ag, sec ? 30'h3e8143e8 : 30'(gp));
            end
        end
    endtask

    task automatic t_scale();
        max_fb = 14'h2710;
        tgt = 10'h1f4;
        settle();
        check(teng, 14'h1388);
        max_fb = 14'h0000;
        tgt = 10'h3e8;
        settle();
        check(teng, 14'h0001);
        for (int k = 0; k < 6; k++)
        begin
            scaling = 3'(k);
            unit_sel = 5'(k * 6);
            settle();
            check(dpos, k > 4 ? 4 : k);
            check(unit_o, k * 6 > 23 ? 23 : k * 6);
            check(upct, k == 0);
        end
    endtask

    task automatic t_forced_dir();
        loop_freq = 12'h1f4;
        forced = 9'h190;
        warn = 1'b1;
        settle();
        check(fcmd, 12'hfa0);
        check(fact, 1'b1);
        warn = 1'b0;
        settle();
        check(fcmd, 12'h1f4);
        fwd = 1'b1;
        rev = 1'b1;
        for (int l = 0; l < 3; l++)
        begin
            dir_lock = 2'(l);
            settle();
            check(rf, l != 2);
            check(rr, l != 1);
            check(rej, l != 0);
        end
    endtask

    task automatic t_carrier();
        for (int s = 1; s < 17; s++)
        begin
            ccfg.sel = 5'(s);
            settle();
            check(car, s == 1 ? 32'h0f : 32'(s * 10));
            check(cheld, 1'b0);
        end
        ccfg.sel = 5'h02;
        ccfg.sensorless_vector_mode = 1'b1;
        settle();
        check(car, 8'h28);
        ccfg = '{sel:5'h0c, soft_pwm:1'b1, default:'0};
        settle();
        check(car, 8'h50);
        check(cheld, 1'b1);
        ccfg.soft_pwm = 1'b0;
        ccfg.auto_lower = 1'b1;
        heat = 1'b1;
        settle();
        check(car, 8'h14);
        check(cheld, 1'b1);
        heat = 1'b0;
        settle();
        check(car, 8'h78);
        ccfg = '{var_max:5'h0a, var_min:5'h02, var_gain:7'h03, default:'0};
        settle();
        check(car, 8'h46);
        check(cvar, 1'b1);
        ccfg.var_max = 5'h05;
        ccfg.var_min = 5'h09;
        settle();
        check(car, 8'h32);
    endtask

    task automatic t_ramp_jump();
        acc_t = 16'h03e8;
        sc = '{acc_start:8'hfa, acc_end:8'hfb, dec_start:8'h03, dec_end:8'h00};
        loop_freq = 12'h258;
        jcfg = '{f1:12'h1f4, f2:12'h21c, f3:12'h000, width:8'h28};
        settle();
        check(atot, 17'h004e2);
        check(dtot, 17'h00001);
        check(fcmd, 12'h258);
        loop_freq = 12'h212;
        settle();
        check(fcmd, 12'h230);
        check(jhold, 1'b1);
        loop_freq = 12'h000;
        settle();
        loop_freq = 12'h1f9;
        settle();
        check(fcmd, 12'h1e0);
        ramping = 1'b1;
        settle();
        check(fcmd, 12'h1f9);
        ramping = 1'b0;
        jcfg.f1 = 12'h000;
        loop_freq = 12'h00a;
        settle();
        check(fcmd, 12'h00a);
        check(jhold, 1'b0);
    endtask

    // main sequence, reset values checked while reset is held
    initial
    begin
        repeat (6) @(negedge clk);
        check(upct, 1'b1);
        check(car, 8'h0f);
        check(fcmd, 12'h000);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_loop();
        t_scale();
        t_forced_dir();
        t_carrier();
        t_ramp_jump();
        print_verdict();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #200us;
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
